// ---- core/scan_rate_sequencer.sv ----
// Functional notes
// - Scan size code: 0 single, 1..5 give 2..32, 6 gives 64, 7 reserved.
// - 64-channel size accepted only in single-ended input mode.
// - Single-channel mode converts only the six-bit picked channel.
// - Trigger source: rate A, rate B, external sync, software bit.
// - Second timer clocked by master clock or first timer output.
// - Timer fires once every divisor ticks of its source.
// - Timer stop bit high suppresses ticks.
// - Timer registers reset to 0001_4E20 and 0000_0018.
// - Scan rate times channels must stay within 100k samples/s; not checked here, left to software.
// - Sample register read-only, 16 bits low, upper bits zero.
// - Offset binary coding when format bit high.
// - Two's complement coding flips the sign bit.
// - Format bit high selects offset binary, low two's complement.
// - Software trigger bit starts one scan, cleared on completion.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module scan_rate_sequencer
   import scan_rate_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rstn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // External sync pin
   input  wire logic                ext_sync_pin,
   // Converter side
   output logic                     conv_start,
   output logic      [5:0]          conv_channel,
   input  wire logic                conv_done,
   input  wire logic [SAMPLE_W-1:0] conv_data,
   // Status
   output logic                     scan_busy
);
   import scan_rate_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b11
   } scan_state_e;

   logic [31:0]         board_control_reg;
   logic [31:0]         first_rate_timer_ctl_reg;
   logic [31:0]         second_rate_timer_ctl_reg;
   logic [31:0]         scan_trigger_config_reg;
   logic [SAMPLE_W-1:0] sample_bits_reg;
   logic [PHASE_W-1:0]  phase_reg;
   logic                master_tick_reg;
   logic                ext_level;
   logic                ext_level_d_reg;
   logic                tick_a;
   logic                tick_b;
   logic                b_src_tick;
   logic                trig;
   logic                scan_done;
   logic                wr_en;
   logic                setup;
   logic [31:0]         rd_word;
   logic                rd_hit;
   scan_state_e         state_reg;
   logic [6:0]          remain_reg;
   logic [6:0]          scan_len;
   logic [31:0]         scan_wr;
   logic [2:0]          size_code;
   logic [2:0]          in_mode;
   logic                init_cmd;

   // Master clock enable: 24 MHz average, jitter of one sys_clk cycle
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         phase_reg       <= '0;
         master_tick_reg <= 1'b0;
      end else if (phase_reg + PHASE_STEP >= PHASE_MOD) begin
         phase_reg       <= phase_reg + PHASE_STEP - PHASE_MOD;
         master_tick_reg <= 1'b1;
      end else begin
         phase_reg       <= phase_reg + PHASE_STEP;
         master_tick_reg <= 1'b0;
      end
   end

   rate_timer #(
      .DIV_W (DIV_W)
   ) u_rate_a (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .src_tick (master_tick_reg),
      .divisor  (first_rate_timer_ctl_reg[DIV_W-1:0]),
      .stop     (first_rate_timer_ctl_reg[TIMER_DIS_BIT]),
      .tick     (tick_a)
   );

   assign b_src_tick = scan_trigger_config_reg[B_SRC_BIT] ? tick_a : master_tick_reg;

   rate_timer #(
      .DIV_W (DIV_W)
   ) u_rate_b (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .src_tick (b_src_tick),
      .divisor  (second_rate_timer_ctl_reg[DIV_W-1:0]),
      .stop     (second_rate_timer_ctl_reg[TIMER_DIS_BIT]),
      .tick     (tick_b)
   );

   pin_sync u_ext_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin     (ext_sync_pin),
      .level   (ext_level)
   );

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ext_level_d_reg <= 1'b0;
      end else begin
         ext_level_d_reg <= ext_level;
      end
   end

   // Trigger selection
   always_comb begin
      case (scan_trigger_config_reg[TRIG_SRC_LSB +: TRIG_SRC_W])
         TRIG_RATE_A: trig = tick_a;
         TRIG_RATE_B: trig = tick_b;
         TRIG_EXT:    trig = ext_level & ~ext_level_d_reg;
         TRIG_SW:     trig = board_control_reg[SW_TRIG_BIT];
         default:     trig = 1'b0;
      endcase
   end

   // Scan length from size code
   assign size_code = scan_trigger_config_reg[SCAN_SIZE_LSB +: SCAN_SIZE_W];
   assign in_mode   = board_control_reg[IN_MODE_LSB +: IN_MODE_W];

   always_comb begin
      case (size_code)
         SIZE_SINGLE: scan_len = 7'd1;
         SIZE_64:     scan_len = (in_mode == IN_MODE_SINGLE_ENDED) ? 7'd64 : 7'd32;
         default:     scan_len = 7'(7'd1 << size_code);
      endcase
   end

   // Scan sequencer; rate checks left to software
   assign scan_done = (state_reg == ST_WAIT) && conv_done && (remain_reg == 7'd1);

   always_ff @(posedge sys_clk) begin
      if (!rstn || init_cmd) begin
         state_reg    <= ST_IDLE;
         remain_reg   <= '0;
         conv_start   <= 1'b0;
         conv_channel <= '0;
         scan_busy    <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (trig) begin
                  remain_reg <= scan_len;
                  scan_busy  <= 1'b1;
                  state_reg  <= ST_ISSUE;
                  if (size_code == SIZE_SINGLE) begin
                     conv_channel <= scan_trigger_config_reg[CH_PICK_LSB +: CH_PICK_W];
                  end else begin
                     conv_channel <= '0;
                  end
               end
            end
            ST_ISSUE: begin
               conv_start <= 1'b1;
               state_reg  <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done) begin
                  remain_reg <= remain_reg - 7'd1;
                  if (remain_reg == 7'd1) begin
                     scan_busy <= 1'b0;
                     state_reg <= ST_IDLE;
                  end else begin
                     conv_channel <= conv_channel + 6'd1;
                     state_reg    <= ST_ISSUE;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Latest converted sample, stored as offset binary
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sample_bits_reg <= '0;
      end else if (state_reg == ST_WAIT && conv_done) begin
         sample_bits_reg <= conv_data;
      end
   end

   // APB decode
   assign setup    = psel && !penable;
   assign wr_en    = psel && penable && pready && pwrite;
   assign init_cmd = wr_en && (paddr == BOARD_CTL_OFS) && pwdata[INIT_BIT];

   // Rejects 64 channels outside single-ended and the reserved code
   always_comb begin
      scan_wr = pwdata & SCAN_CFG_WMASK;
      if (pwdata[SCAN_SIZE_LSB +: SCAN_SIZE_W] == SIZE_RESERVED ||
          (pwdata[SCAN_SIZE_LSB +: SCAN_SIZE_W] == SIZE_64 &&
           in_mode != IN_MODE_SINGLE_ENDED)) begin
         scan_wr[SCAN_SIZE_LSB +: SCAN_SIZE_W] = size_code;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn || init_cmd) begin
         first_rate_timer_ctl_reg  <= RATE_A_RST;
         second_rate_timer_ctl_reg <= RATE_B_RST;
         scan_trigger_config_reg   <= SCAN_CFG_RST;
      end else if (wr_en) begin
         case (paddr)
            RATE_A_OFS:   first_rate_timer_ctl_reg  <= pwdata & RATE_WMASK;
            RATE_B_OFS:   second_rate_timer_ctl_reg <= pwdata & RATE_WMASK;
            SCAN_CFG_OFS: scan_trigger_config_reg   <= scan_wr;
            default:      ;
         endcase
      end
   end

   // Software trigger: a set in the completing cycle wins over the clear
   always_ff @(posedge sys_clk) begin
      if (!rstn || init_cmd) begin
         board_control_reg <= BOARD_CTL_RST;
      end else if (wr_en && paddr == BOARD_CTL_OFS) begin
         board_control_reg <= (pwdata & BOARD_CTL_WMASK) | (BOARD_CTL_RST & ~BOARD_CTL_WMASK);
         if (!pwdata[SW_TRIG_BIT] && !(scan_done || trig)) begin
            board_control_reg[SW_TRIG_BIT] <= board_control_reg[SW_TRIG_BIT];
         end
      end else if (scan_done &&
                   scan_trigger_config_reg[TRIG_SRC_LSB +: TRIG_SRC_W] == TRIG_SW) begin
         board_control_reg[SW_TRIG_BIT] <= 1'b0;
      end
   end

   // Read mux
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case (paddr)
         BOARD_CTL_OFS: rd_word = board_control_reg;
         SAMPLE_OFS: begin
            rd_word = {16'h0000, sample_bits_reg};
            if (!board_control_reg[OFS_BIN_BIT]) begin
               rd_word[SAMPLE_W-1] = ~sample_bits_reg[SAMPLE_W-1];
            end
         end
         RATE_A_OFS:    rd_word = first_rate_timer_ctl_reg;
         RATE_B_OFS:    rd_word = second_rate_timer_ctl_reg;
         SCAN_CFG_OFS:  rd_word = scan_trigger_config_reg;
         default:       rd_hit  = 1'b0;
      endcase
   end

   // No wait states; unmapped addresses answer with an error
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !rd_hit;
         if (setup && !pwrite) begin
            prdata <= rd_word;
         end
      end
   end
endmodule // scan_rate_sequencer

// ---- core/scan_rate_pkg.sv ----
package scan_rate_pkg;
   // Register byte offsets
   localparam logic [7:0] BOARD_CTL_OFS     = 8'h00;
   localparam logic [7:0] SAMPLE_OFS        = 8'h08;
   localparam logic [7:0] RATE_A_OFS        = 8'h10;
   localparam logic [7:0] RATE_B_OFS        = 8'h14;
   localparam logic [7:0] SCAN_CFG_OFS      = 8'h20;
   // Reset values
   localparam logic [31:0] BOARD_CTL_RST    = 32'h0000_4060;
   localparam logic [31:0] RATE_A_RST       = 32'h0001_4E20;
   localparam logic [31:0] RATE_B_RST       = 32'h0000_0018;
   localparam logic [31:0] SCAN_CFG_RST     = 32'h0000_040D;
   // Writable masks
   localparam logic [31:0] BOARD_CTL_WMASK  = 32'h0000_B1F7;
   localparam logic [31:0] RATE_WMASK       = 32'h0001_FFFF;
   localparam logic [31:0] SCAN_CFG_WMASK   = 32'h0007_F7FF;
   // Board control fields
   localparam int IN_MODE_LSB   = 0;
   localparam int IN_MODE_W     = 3;
   localparam int OFS_BIN_BIT   = 6;
   localparam int SW_TRIG_BIT   = 12;
   localparam int INIT_BIT      = 15;
   localparam logic [2:0] IN_MODE_SINGLE_ENDED = 3'h1;
   // Scan configuration fields
   localparam int SCAN_SIZE_LSB = 0;
   localparam int SCAN_SIZE_W   = 3;
   localparam int TRIG_SRC_LSB  = 3;
   localparam int TRIG_SRC_W    = 2;
   localparam int B_SRC_BIT     = 10;
   localparam int CH_PICK_LSB   = 12;
   localparam int CH_PICK_W     = 6;
   // Scan size codes
   localparam logic [2:0] SIZE_SINGLE   = 3'h0;
   localparam logic [2:0] SIZE_32       = 3'h5;
   localparam logic [2:0] SIZE_64       = 3'h6;
   localparam logic [2:0] SIZE_RESERVED = 3'h7;
   // Trigger sources
   localparam logic [1:0] TRIG_RATE_A   = 2'h0;
   localparam logic [1:0] TRIG_RATE_B   = 2'h1;
   localparam logic [1:0] TRIG_EXT      = 2'h2;
   localparam logic [1:0] TRIG_SW       = 2'h3;
   // Rate timer fields
   localparam int DIV_W         = 16;
   localparam int TIMER_DIS_BIT = 16;
   // Timing: master clock derived from sys_clk by a phase accumulator
   localparam int SYS_CLK_HZ    = 250_000_000;
   localparam int MASTER_HZ     = 24_000_000;
   localparam int PHASE_W       = 28;
   localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(MASTER_HZ / 1000);
   localparam logic [PHASE_W-1:0] PHASE_MOD  = PHASE_W'(SYS_CLK_HZ / 1000);
   // Sample coding
   localparam int SAMPLE_W      = 16;
endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // Pin and filtered level
   input  wire logic pin,
   output logic      level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Change accepted only once two later stages agree
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         level <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
endmodule // pin_sync

// ---- core/rate_timer.sv ----
`timescale 1ns/1ps
module rate_timer #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             src_tick,
   input  wire logic [DIV_W-1:0] divisor,
   input  wire logic             stop,
   // Output
   output logic                  tick
);
   logic [DIV_W:0] cnt_reg;
   logic [DIV_W:0] cnt_next;

   assign cnt_next = cnt_reg + 1'b1;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (stop) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (src_tick) begin
         // Divisor 0 behaves as 1 to avoid a dead timer
         if (cnt_next >= {1'b0, divisor}) begin
            cnt_reg <= '0;
            tick    <= 1'b1;
         end else begin
            cnt_reg <= cnt_next;
            tick    <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end
endmodule // rate_timer

// ---- tb/conv_model.sv ----
`timescale 1ns/1ps
module conv_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Converter handshake
   input  wire logic        conv_start,
   input  wire logic [2:0]  lag,
   input  wire logic [15:0] level,
   output logic             conv_done,
   output logic [15:0]      conv_data
);
   logic [2:0] cnt_reg;
   logic       run_reg;
   always_ff @(posedge sys_clk) begin
      conv_done <= 1'b0;
      // Stale data toggles so nothing may rely on it
      conv_data <= ~conv_data;
      if (!rstn) begin
         run_reg <= 1'b0;
         conv_data <= 16'h0;
      end else if (conv_start) begin
         run_reg <= 1'b1;
         cnt_reg <= lag;
      end else if (run_reg && cnt_reg == 3'h0) begin
         run_reg <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= level;
      end else begin
         cnt_reg <= cnt_reg - 3'h1;
      end
   end
endmodule // conv_model

// ---- tb/scan_rate_assertions.sv ----
`timescale 1ns/1ps
module scan_rate_checks
   import scan_rate_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Converter
   input wire logic        conv_start,
   input wire logic [5:0]  conv_channel,
   input wire logic        conv_done,
   input wire logic        scan_busy
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence mid_done_s;
      conv_done ##1 scan_busy;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   sample_upper_zero_a:
      assert property (pready && !pwrite && paddr == SAMPLE_OFS |-> prdata[31:16] == 16'h0)
      else $error("sample upper bits set");
   scan_first_start_a: assert property ($rose(scan_busy) |=> conv_start)
      else $error("scan began without start");
   next_start_a: assert property (mid_done_s |=> conv_start)
      else $error("no start after done");
   channel_step_a:
      assert property (conv_done && scan_busy |=>
         !scan_busy || conv_channel == $past(conv_channel) + 6'h1)
      else $error("channel not ascending");
   start_in_scan_a: assert property (conv_start |-> scan_busy && $stable(conv_channel))
      else $error("start outside scan");
   busy_end_a: assert property ($fell(scan_busy) |-> $past(conv_done))
      else $error("scan ended without done");
endmodule // scan_rate_checks

bind scan_rate_sequencer scan_rate_checks i_checks (
   .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
   .scan_busy(scan_busy)
);

// ---- tb/test_scan_rate_sequencer.sv ----
`timescale 1ns/1ps
module test_scan_rate_sequencer;
   import scan_rate_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        ext_sync_pin = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] lvl = 16'h0;
   logic [2:0]  lag = 3'h0;
   logic [15:0] seed = 16'h002B;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr, conv_start, conv_done, scan_busy, busy_d, ofs_m;
   logic [5:0]  conv_channel, pick_m;
   logic [15:0] conv_data;
   logic [2:0]  mode_m;
   logic [2:0]  sz_m = 3'h5;
   logic [5:0]  ch_q[$];
   logic [15:0] corner[4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
   int          rise_q[$];
   int          cyc = 0;
   int          mismatches = 0;
   int          samples_checked = 0;

   scan_rate_sequencer i_dut (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_sync_pin(ext_sync_pin), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_data(conv_data), .scan_busy(scan_busy));
   conv_model i_conv (.sys_clk(sys_clk), .rstn(rstn), .conv_start(conv_start), .lag(lag),
      .level(lvl), .conv_done(conv_done), .conv_data(conv_data));

   initial forever #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      busy_d <= scan_busy;
      if (conv_start === 1'b1) ch_q.push_back(conv_channel);
      if (scan_busy === 1'b1 && busy_d !== 1'b1) rise_q.push_back(cyc);
   end

   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic hang();
      chk("wait_bound", 32'h0, 32'h1);
      report_and_stop();
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (scan_busy !== v) begin
         @(posedge sys_clk);
         if (++n > 12000) hang();
      end
   endtask

   // Model drops reserved code, and 64 outside single-ended mode
   task automatic set_cfg(input logic [2:0] c, input logic [1:0] t, input logic b);
      if (c != 3'h7 && (c != 3'h6 || mode_m == 3'h1)) sz_m = c;
      pick_m = 6'(rnd());
      apb(1'b1, SCAN_CFG_OFS, {14'h0, pick_m, 1'b0, b, 5'h0, t, c});
      apb(1'b0, SCAN_CFG_OFS, 32'h0);
      chk("scan_cfg", {14'h0, pick_m, 1'b0, b, 5'h0, t, sz_m}, rdat);
   endtask

   task automatic sw_scan(input logic [15:0] v);
      int n;
      void'(rnd());
      lag <= seed[2:0];
      lvl <= v;
      ch_q.delete();
      apb(1'b1, BOARD_CTL_OFS, {19'h0, 1'b1, 5'h0, ofs_m, 3'h0, mode_m});
      wait_busy(1'b1);
      wait_busy(1'b0);
      n = (sz_m == 3'h0) ? 1 : (1 << sz_m);
      chk("scan_len", n, ch_q.size());
      foreach (ch_q[i]) chk("channel", (sz_m == 3'h0) ? pick_m : i, ch_q[i]);
      apb(1'b0, BOARD_CTL_OFS, 32'h0);
      chk("sw_bit", 32'h0, rdat[12]);
      apb(1'b0, SAMPLE_OFS, 32'h0);
      chk("sample", {16'h0, v ^ {~ofs_m, 15'h0}}, rdat);
   endtask

   task automatic timed(input logic [31:0] a, input logic [31:0] b, input logic [1:0] t,
                        input logic s, input int gap);
      int n;
      int g;
      set_cfg(3'h0, t, s);
      apb(1'b1, RATE_A_OFS, a);
      apb(1'b1, RATE_B_OFS, b);
      rise_q.delete();
      for (n = 0; n < 4 * gap && rise_q.size() < 3; n++) @(posedge sys_clk);
      if (rise_q.size() < 3) hang();
      g = rise_q[2] - rise_q[1];
      chk("gap_ok", 32'h1, (g >= gap - 2) && (g <= gap + 2));
      apb(1'b1, RATE_A_OFS, 32'h0001_00F0);
      apb(1'b1, RATE_B_OFS, 32'h0001_00F0);
   endtask

   task automatic pulse();
      ext_sync_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_sync_pin <= 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      apb(1'b0, RATE_A_OFS, 32'h0);
      chk("rate_a", 32'h0001_4E20, rdat);
      apb(1'b0, RATE_B_OFS, 32'h0);
      chk("rate_b", 32'h0000_0018, rdat);
      apb(1'b0, SCAN_CFG_OFS, 32'h0);
      chk("scan_cfg", 32'h0000_040D, rdat);
      apb(1'b0, 8'h04, 32'h0);
      chk("unmapped", 32'h1, rerr);
      $display("reset test done");
      mode_m = 3'h1;
      ofs_m = 1'b1;
      for (int c = 0; c < 8; c++) begin
         set_cfg(3'(c), 2'h3, 1'b1);
         sw_scan(rnd());
      end
      mode_m = 3'h0;
      set_cfg(3'h3, 2'h3, 1'b1);
      sw_scan(rnd());
      set_cfg(3'h6, 2'h3, 1'b1);
      sw_scan(rnd());
      $display("scan size test done");
      set_cfg(3'h0, 2'h3, 1'b1);
      for (int f = 0; f < 8; f++) begin
         ofs_m = 1'(f);
         sw_scan(corner[f >> 1]);
      end
      apb(1'b1, SAMPLE_OFS, 32'hFFFF_FFFF);
      apb(1'b0, SAMPLE_OFS, 32'h0);
      chk("sample_ro", 32'h0, rdat);
      $display("coding test done");
      timed(32'h0000_00F0, 32'h0001_0018, 2'h0, 1'b1, 2500);
      // Cascaded divisor below 240 still keeps the scan rate legal
      timed(32'h0000_00F0, 32'h0000_0002, 2'h1, 1'b1, 5000);
      timed(32'h0001_00F0, 32'h0000_0168, 2'h1, 1'b0, 3750);
      rise_q.delete();
      repeat (4000) @(posedge sys_clk);
      chk("stopped", 32'h0, rise_q.size());
      $display("timer test done");
      set_cfg(3'h4, 2'h2, 1'b1);
      ch_q.delete();
      rise_q.delete();
      pulse();
      wait_busy(1'b1);
      pulse();
      wait_busy(1'b0);
      repeat (20) @(posedge sys_clk);
      chk("ext_scans", 32'h1, rise_q.size());
      chk("ext_len", 32'h10, ch_q.size());
      $display("sync test done");
      rstn <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      apb(1'b0, SCAN_CFG_OFS, 32'h0);
      chk("rst_cfg", 32'h0000_040D, rdat);
      apb(1'b1, RATE_A_OFS, 32'h0000_1234);
      apb(1'b1, BOARD_CTL_OFS, 32'h0000_8000);
      apb(1'b0, RATE_A_OFS, 32'h0);
      chk("init_rate_a", 32'h0001_4E20, rdat);
      apb(1'b0, BOARD_CTL_OFS, 32'h0);
      chk("init_bcr", 32'h0000_4060, rdat);
      $display("init test done");
      report_and_stop();
   end
endmodule // test_scan_rate_sequencer
